//--- bbrp_pkg.sv
package bbrp_pkg;

	// register offsets on the plain register port (byte addresses)
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_MAX_PAY = 5'h04;
	localparam logic [4:0] REG_STATUS = 5'h08;
	localparam logic [4:0] REG_IRQ_CLR = 5'h0C;
	localparam logic [4:0] REG_IRQ_EN = 5'h10;
	localparam logic [4:0] REG_SEQ = 5'h14;
	localparam logic [4:0] REG_PKT_CNT = 5'h18;

	// field positions
	localparam int unsigned CTRL_ENABLE = 0;
	localparam int unsigned CTRL_BUSY = 1;
	localparam int unsigned EV_SET_DONE = 0;
	localparam int unsigned EV_PKT_SENT = 1;
	localparam int unsigned EV_DROPPED = 2;
	localparam int unsigned EV_W = 3;

	// values after reset
	localparam logic [15:0] MAX_PAY_RST = 16'h05B4;
	localparam logic [15:0] SEQ_RST = 16'h0000;
	localparam logic CTRL_ENABLE_RST = 1'h1;

	// fixed header content and addressing
	localparam logic [31:0] MCAST_GROUP = 32'hEF003330;
	localparam logic [15:0] PORT_BASE = 16'h7530;
	localparam logic [7:0] RTP_BYTE0 = 8'h80;
	localparam logic [6:0] PAYLOAD_TYPE = 7'h4E;
	localparam logic [3:0] HDR_LAST = 4'hB;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_HDR,
		ST_PAY
	} bbrp_state_e_t;

	// one baseband packet as announced at the start strobe
	typedef struct packed {
		logic [31:0] len;
		logic [5:0] pipe;
		logic [31:0] sec;
		logic [31:0] nsec;
	} bbrp_desc_t;

	typedef struct packed {
		logic marker;
		logic [15:0] seq;
		logic [31:0] stamp;
		logic [31:0] ssrc;
	} bbrp_hdr_t;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
		logic sop;
		logic eop;
		logic [31:0] dst_ip;
		logic [15:0] dst_port;
	} bbrp_out_t;

	typedef struct packed {
		bbrp_state_e_t st;
		logic [5:0] pipe;
		bbrp_hdr_t hdr;
		logic [3:0] idx;
		logic [31:0] remain;
		logic [15:0] seg;
		logic in_ready;
		bbrp_out_t out;
		logic enable;
		logic [15:0] max_pay;
		logic [15:0] seq_next;
		logic [31:0] pkt_cnt;
		logic [EV_W-1:0] status;
		logic [EV_W-1:0] irq_en;
		logic irq;
		logic [31:0] rdata;
	} bbrp_state_t;

endpackage

//--- bbrp_hdr_byte.sv
// picks one byte of the 12-byte fixed header, network byte order
module bbrp_hdr_byte (
	input wire bbrp_pkg::bbrp_hdr_t hdr,
	input wire logic [3:0] idx,
	output logic [7:0] hbyte
);

	always_comb begin
		case (idx)
			4'h0: hbyte = bbrp_pkg::RTP_BYTE0;
			4'h1: hbyte = {hdr.marker, bbrp_pkg::PAYLOAD_TYPE};
			4'h2: hbyte = hdr.seq[15:8];
			4'h3: hbyte = hdr.seq[7:0];
			4'h4: hbyte = hdr.stamp[31:24];
			4'h5: hbyte = hdr.stamp[23:16];
			4'h6: hbyte = hdr.stamp[15:8];
			4'h7: hbyte = hdr.stamp[7:0];
			4'h8: hbyte = hdr.ssrc[31:24];
			4'h9: hbyte = hdr.ssrc[23:16];
			4'hA: hbyte = hdr.ssrc[15:8];
			4'hB: hbyte = hdr.ssrc[7:0];
			default: hbyte = 8'h00;
		endcase
	end

endmodule

//--- bbrp_packetizer.sv
// Notes on behaviour
// - Every packet goes to group 239.0.51.48, destination port 30000 plus the pipe number 0..63.
// - A packet payload holds bytes of exactly one baseband packet, never of two.
// - A baseband packet is cut into as many packets as the maximum payload size needs.
// - The marker is 1 in the packet that starts the baseband packet and 0 in every other one.
// - All packets of one set carry the same timestamp, taken from the frame emission time.
// - The first packet of a set carries the total byte length of the baseband packet in SSRC.
// - Every packet with marker 0 carries zero in SSRC.
// - The extension bit is always 0.
// - The contributing-source count is 0 and no such list follows.
// - The payload type is 78 in every packet.
// - Sequence numbers advance by one per packet and padding follows plain RTP (none here).
// - The timestamp is seconds bits 21..0 followed by nanoseconds bits 29..20.
module bbrp_packetizer (
	input wire logic clk,
	input wire logic srst,
	input wire logic start,
	input wire bbrp_pkg::bbrp_desc_t start_desc,
	input wire logic in_valid,
	input wire logic [7:0] in_data,
	output logic in_ready,
	output bbrp_pkg::bbrp_out_t pkt_out,
	input wire logic [4:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic irq
);

	////////////////////////////////////////////////////////////////////////////////
	bbrp_pkg::bbrp_state_t q;
	bbrp_pkg::bbrp_state_t n;
	logic [7:0] hbyte;
	logic start_ok;
	logic take;
	logic set_end;
	logic pkt_end;
	logic [bbrp_pkg::EV_W-1:0] ev;
	logic [bbrp_pkg::EV_W-1:0] clr;

	bbrp_hdr_byte u_hdr (
		.hdr(q.hdr),
		.idx(q.idx),
		.hbyte(hbyte)
	);

	assign start_ok = (q.st == bbrp_pkg::ST_IDLE) && start && q.enable && (start_desc.len != 32'h0);
	assign take = (q.st == bbrp_pkg::ST_PAY) && in_valid && q.in_ready;
	assign set_end = take && (q.remain == 32'h1);
	// compare with >= so a smaller size written mid-packet still cuts the packet
	assign pkt_end = take && (set_end || ((q.seg + 16'h1) >= q.max_pay));

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		n = q;
		ev = '0;
		clr = '0;
		n.out.valid = 1'b0;
		n.out.sop = 1'b0;
		n.out.eop = 1'b0;
		n.rdata = 32'h0;
		case (q.st)
			bbrp_pkg::ST_IDLE: begin
				n.in_ready = 1'b0;
				if (start_ok) begin
					n.pipe = start_desc.pipe;
					n.remain = start_desc.len;
					n.hdr.stamp = {start_desc.sec[21:0], start_desc.nsec[29:20]};
					n.hdr.marker = 1'b1;
					n.hdr.ssrc = start_desc.len;
					n.hdr.seq = q.seq_next;
					n.seq_next = q.seq_next + 16'h1;
					n.idx = 4'h0;
					n.st = bbrp_pkg::ST_HDR;
				end
			end
			bbrp_pkg::ST_HDR: begin
				n.out.valid = 1'b1;
				n.out.data = hbyte;
				n.out.sop = (q.idx == 4'h0);
				n.out.dst_ip = bbrp_pkg::MCAST_GROUP;
				n.out.dst_port = bbrp_pkg::PORT_BASE + {10'h000, q.pipe};
				n.idx = q.idx + 4'h1;
				if (q.idx == bbrp_pkg::HDR_LAST) begin
					n.st = bbrp_pkg::ST_PAY;
					n.seg = 16'h0;
					n.in_ready = 1'b1;
				end
			end
			bbrp_pkg::ST_PAY: begin
				if (take) begin
					n.out.valid = 1'b1;
					n.out.data = in_data;
					n.seg = q.seg + 16'h1;
					n.remain = q.remain - 32'h1;
				end
				// stop pulling bytes at a packet edge so no packet mixes two sets
				if (pkt_end) begin
					n.out.eop = 1'b1;
					n.in_ready = 1'b0;
					n.pkt_cnt = q.pkt_cnt + 32'h1;
					ev[bbrp_pkg::EV_PKT_SENT] = 1'b1;
					if (set_end) begin
						n.st = bbrp_pkg::ST_IDLE;
						ev[bbrp_pkg::EV_SET_DONE] = 1'b1;
					end else begin
						n.hdr.marker = 1'b0;
						n.hdr.ssrc = 32'h0;
						n.hdr.seq = q.seq_next;
						n.seq_next = q.seq_next + 16'h1;
						n.idx = 4'h0;
						n.st = bbrp_pkg::ST_HDR;
					end
				end
			end
			default: begin
				n.st = bbrp_pkg::ST_IDLE;
			end
		endcase
		// a start that cannot be served is not queued, only reported
		if (start && !start_ok) begin
			ev[bbrp_pkg::EV_DROPPED] = 1'b1;
		end
		if (reg_wr) begin
			case (reg_addr)
				bbrp_pkg::REG_CTRL: n.enable = reg_wdata[bbrp_pkg::CTRL_ENABLE];
				bbrp_pkg::REG_MAX_PAY: n.max_pay = (reg_wdata[15:0] == 16'h0) ? 16'h1 : reg_wdata[15:0];
				bbrp_pkg::REG_IRQ_CLR: clr = reg_wdata[bbrp_pkg::EV_W-1:0];
				bbrp_pkg::REG_IRQ_EN: n.irq_en = reg_wdata[bbrp_pkg::EV_W-1:0];
				bbrp_pkg::REG_SEQ: n.seq_next = reg_wdata[15:0];
				default: n.enable = n.enable;
			endcase
		end
		// set wins over a clear in the same cycle
		n.status = (q.status & ~clr) | ev;
		n.irq = |(n.status & n.irq_en);
		if (reg_rd) begin
			case (reg_addr)
				bbrp_pkg::REG_CTRL: n.rdata = {30'h0, (q.st != bbrp_pkg::ST_IDLE), q.enable};
				bbrp_pkg::REG_MAX_PAY: n.rdata = {16'h0, q.max_pay};
				bbrp_pkg::REG_STATUS: n.rdata = {29'h0, q.status};
				bbrp_pkg::REG_IRQ_EN: n.rdata = {29'h0, q.irq_en};
				bbrp_pkg::REG_SEQ: n.rdata = {16'h0, q.seq_next};
				bbrp_pkg::REG_PKT_CNT: n.rdata = q.pkt_cnt;
				default: n.rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			q <= '0;
			q.max_pay <= bbrp_pkg::MAX_PAY_RST;
			q.seq_next <= bbrp_pkg::SEQ_RST;
			q.enable <= bbrp_pkg::CTRL_ENABLE_RST;
		end else begin
			q <= n;
		end
	end

	assign in_ready = q.in_ready;
	assign pkt_out = q.out;
	assign reg_rdata = q.rdata;
	assign irq = q.irq;

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	fixed_byte0_a: assert property (q.out.valid && q.out.sop |-> q.out.data == 8'h80)
		else $error("first header byte is not version 2 with X and CC clear");

	ptype_field_a: assert property (q.out.valid && $past(q.out.sop) |-> q.out.data[6:0] == 7'h4E)
		else $error("payload type is not 78");

	first_marker_a: assert property (start_ok |-> ##3 q.out.data[7])
		else $error("first packet of a set lacks the marker");

	cont_marker_a: assert property (q.out.eop && q.st == bbrp_pkg::ST_HDR |-> ##2 !q.out.data[7])
		else $error("continuation packet carries the marker");

	cont_ssrc_a: assert property (q.out.eop && q.st == bbrp_pkg::ST_HDR |-> ##9 (q.out.data == 8'h00) [*4])
		else $error("continuation packet has nonzero source field");

	seq_step_a: assert property (q.st == bbrp_pkg::ST_HDR |-> q.seq_next == q.hdr.seq + 16'h1)
		else $error("sequence number did not advance by one");

	stamp_hold_a: assert property (q.st != bbrp_pkg::ST_IDLE && $past(q.st) != bbrp_pkg::ST_IDLE |-> $stable(q.hdr.stamp))
		else $error("timestamp changed inside a set");

	set_close_a: assert property (q.out.eop && q.st == bbrp_pkg::ST_IDLE |-> q.remain == 32'h0)
		else $error("set closed before its announced length");

	seg_bound_a: assert property (q.st == bbrp_pkg::ST_PAY |-> q.seg <= q.max_pay)
		else $error("packet payload exceeds the maximum size");

	dest_port_a: assert property (q.out.valid |-> q.out.dst_port == 16'h7530 + {10'h000, q.pipe} && q.out.dst_ip == 32'hEF003330)
		else $error("wrong multicast destination");

endmodule

//--- bbrp_rx_model.sv
module bbrp_rx_model (
	input wire logic clk,
	input wire logic srst,
	input wire bbrp_pkg::bbrp_out_t pkt_in,
	output int sets_ok,
	output int sets_lost
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [95:0] hdr;
	logic open_q;
	logic [15:0] seq_exp;
	int idx, acc, need;
	////////////////////////////////////////////////////////////////////////
	// the link keeps order here, so reordering reduces to a sequence check
	always @(posedge clk) begin
		if (srst) begin
			sets_ok = 0;
			sets_lost = 0;
			open_q = 1'b0;
			idx = 0;
		end else if (pkt_in.valid) begin
			if (pkt_in.sop)
				idx = 0;
			if (idx < 12)
				hdr = {hdr[87:0], pkt_in.data};
			else if (open_q) begin
				acc++;
				if (acc == need) begin
					sets_ok++;
					open_q = 1'b0;
				end
			end
			if (idx == 11) begin
				if (hdr[87]) begin
					if (open_q)
						sets_lost++;
					open_q = 1'b1;
					need = int'(hdr[31:0]);
					acc = 0;
				end else if (open_q && hdr[79:64] !== seq_exp) begin
					sets_lost++;
					open_q = 1'b0;
				end
				// marker-0 packets with nothing open fall through unused
				seq_exp = hdr[79:64] + 16'h0001;
			end
			idx++;
		end
	end
endmodule

//--- bbrp_packetizer_tb.sv
module bbrp_packetizer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic start = 1'b0;
	bbrp_pkg::bbrp_desc_t desc = '0;
	logic in_valid = 1'b0;
	logic [7:0] in_data = 8'h00;
	logic in_ready, irq, first;
	bbrp_pkg::bbrp_out_t pkt_out;
	logic [4:0] reg_addr = 5'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata, e_len, e_stamp;
	logic [95:0] hdr;
	logic [15:0] e_seq;
	logic [5:0] e_pipe;
	logic [7:0] e_byte = 8'h00;
	int miscompares = 0;
	int n_tests = 0;
	int sets_ok, sets_lost, idx, pay, rem, e_max;
	always #5 clk = ~clk;
	bbrp_packetizer i_bbrp_packetizer (.clk(clk), .srst(srst), .start(start),
		.start_desc(desc), .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready),
		.pkt_out(pkt_out), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
	bbrp_rx_model i_bbrp_rx_model (.clk(clk), .srst(srst), .pkt_in(pkt_out),
		.sets_ok(sets_ok), .sets_lost(sets_lost));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [4:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask
	task go(input logic [31:0] len, input logic [5:0] pipe, input logic [31:0] s, ns);
		e_len = len;
		rem = int'(len);
		first = 1'b1;
		e_pipe = pipe;
		e_stamp = {s[21:0], ns[29:20]};
		@(posedge clk);
		start <= 1'b1;
		desc <= '{len: len, pipe: pipe, sec: s, nsec: ns};
		@(posedge clk);
		start <= 1'b0;
	endtask
	task settle;
		int k;
		for (k = 0; k < 400 && rem != 0; k++)
			@(posedge clk);
		repeat (4) @(posedge clk);
		#1;
	endtask
	////////////////////////////////////////////////////////////////////////
	// source with a gap every other cycle, so the payload path sees stalls
	always @(posedge clk) begin
		in_valid <= ~in_valid;
		if (in_valid && in_ready)
			in_data <= in_data + 8'h01;
	end
	always @(posedge clk) begin
		if (!srst && pkt_out.valid) begin
			if (pkt_out.sop) begin
				idx = 0;
				pay = 0;
				chk(pkt_out.dst_ip, bbrp_pkg::MCAST_GROUP);
				chk({16'h0, pkt_out.dst_port}, 32'h7530 + 32'(e_pipe));
			end
			if (idx < 12)
				hdr = {hdr[87:0], pkt_out.data};
			else begin
				chk({24'h0, pkt_out.data}, {24'h0, e_byte});
				e_byte++;
				pay++;
			end
			idx++;
			if (pkt_out.eop) begin
				chk({16'h0, hdr[95:80]}, {24'h80, first, 7'h4E});
				chk({16'h0, hdr[79:64]}, {16'h0, e_seq});
				chk(hdr[63:32], e_stamp);
				chk(hdr[31:0], first ? e_len : 32'h0);
				chk(32'(pay), 32'((rem < e_max) ? rem : e_max));
				rem -= pay;
				e_seq++;
				first = 1'b0;
			end
		end
	end
	initial begin
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		rd(bbrp_pkg::REG_CTRL, 32'h1);
		rd(bbrp_pkg::REG_MAX_PAY, 32'h5B4);
		rd(bbrp_pkg::REG_SEQ, 32'h0);
		rd(5'h1C, 32'h0);
		wr(bbrp_pkg::REG_MAX_PAY, 32'h3);
		e_max = 3;
		wr(bbrp_pkg::REG_SEQ, 32'hFFFE);
		e_seq = 16'hFFFE;
		wr(bbrp_pkg::REG_IRQ_EN, 32'h1);
		go(32'h7, 6'h3F, 32'hABCDE123, 32'h3B9AC9FF);
		rd(bbrp_pkg::REG_CTRL, 32'h3);
		// a second start while busy must be dropped, not merged into this set
		@(posedge clk);
		start <= 1'b1;
		desc.len <= 32'h9;
		@(posedge clk);
		start <= 1'b0;
		settle;
		chk(32'(rem), 32'h0);
		chk({31'h0, irq}, 32'h1);
		rd(bbrp_pkg::REG_STATUS, 32'h7);
		rd(bbrp_pkg::REG_PKT_CNT, 32'h3);
		rd(bbrp_pkg::REG_SEQ, 32'h1);
		wr(bbrp_pkg::REG_IRQ_CLR, 32'h1);
		settle;
		chk({31'h0, irq}, 32'h0);
		wr(bbrp_pkg::REG_IRQ_EN, 32'h4);
		settle;
		chk({31'h0, irq}, 32'h1);
		wr(bbrp_pkg::REG_IRQ_CLR, 32'h7);
		wr(bbrp_pkg::REG_STATUS, 32'h7);
		settle;
		chk({31'h0, irq}, 32'h0);
		rd(bbrp_pkg::REG_STATUS, 32'h0);
		go(32'h2, 6'h00, 32'h0, 32'h0);
		settle;
		chk(32'(rem), 32'h0);
		rd(bbrp_pkg::REG_PKT_CNT, 32'h4);
		chk(32'(sets_ok), 32'h2);
		chk(32'(sets_lost), 32'h0);
		give_verdict;
	end
	initial begin
		repeat (3000) @(posedge clk);
		miscompares++;
		give_verdict;
	end
endmodule
